/* File: bench/serial_vid_startup_control_tb.sv */
// Self-checking bench for the start-up controller
`timescale 1ns/10ps
module serial_vid_startup_control_tb import serial_voltage_code_pkg::*;;
  // *****
  // Harness
  // *****
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  pin_in_t pins = '0;
  logic vidClk, hostData, busData, dOut, dOe, eaLow, track, charge, discharge;
  logic regulation_good_output, disabled, psiN, fixedMode, rxOn;
  dac_pair_t dac;
  int numErrors = 0;
  int checksDone = 0;
  logic [6:0] bootTab [4] = '{7'h24, 7'h2c, 7'h34, 7'h3c};
  logic [6:0] fixTab [4] = '{7'h0c, 7'h1c, 7'h2c, 7'h3c};
  logic [7:0] adr [8] = '{8'hc4, 8'hc2, 8'hde, 8'ha8, 8'hc5, 8'hcc, 8'hde, 8'hd4};
  logic [7:0] dat [8] = '{8'h10, 8'h95, 8'h60, 8'h12, 8'h12, 8'h80, 8'hfe, 8'h20};
  logic [13:0] dacx [8] = '{14'h083c, 14'h0815, 14'h2a54, 14'h2a54, 14'h2a54, 14'h0054,
    14'h0054, 14'h1054};
  logic [7:0] noAck = 8'h18;
  logic [7:0] psiBits = 8'h62;
  // Open-drain data line with pull-up
  assign busData = hostData & ~(dOe & ~dOut);
  serial_vid_startup_control u_serial_vid_startup_control (.sys_clk, .rst,
    .enableIn(pins.enable), .hostPowerReadyInput(pins.powerReady),
    .powerReadyAtGateRail(pins.powerReadyAtRail), .gateSupplyUv(pins.gateSupplyUv),
    .overCurrent(pins.overCurrent), .overVoltage(pins.overVoltage),
    .remoteSenseLinesOpen(pins.senseOpen), .phaseChainOpen(pins.chainOpen),
    .ssAboveEaClamp(pins.ssAboveEaClamp), .ssAboveDelay(pins.ssAboveDelay),
    .ssAtDischargeFloor(pins.ssAtDischargeFloor), .ssBelowDisable(pins.ssBelowDisable),
    .serialVidClock(vidClk), .serialVidDataIn(busData), .serialVidDataOut(dOut),
    .serialVidDataOe(dOe), .errorAmpOutputHoldLow(eaLow), .trackSoftstart(track),
    .softstartCharge(charge), .softstartDischarge(discharge), .regulationGoodOutput(regulation_good_output),
    .outputDisabled(disabled), .powerSaveIndicator_n(psiN), .referenceDacLevel(dac),
    .fixedVoltageMode(fixedMode), .receiverEnabled(rxOn));
  serial_voltage_code_host_model u_serial_voltage_code_host_model (.sys_clk, .busData, .vidClk, .hostData);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2000000;
    numErrors++;
    wrapUp();
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrapUp
  // *****
  // Scenarios
  // *****
  task automatic bootCodes(input logic fixed);
    logic [6:0] exp;
    for (int c = 0; c < 4; c++) begin
      pins.enable <= 1'h0;
      pins.powerReadyAtRail <= fixed;
      u_serial_voltage_code_host_model.park(c[1], c[0]);
      tick(8);
      check("eaLow", eaLow, 1'h1);
      pins.enable <= 1'h1;
      tick(8);
      exp = fixed ? fixTab[c] : bootTab[c];
      check("dac", dac, {exp, exp});
      check("fixed", fixedMode, fixed);
      check("charge", charge, 1'h1);
    end
    $display("boot codes done, fixed %0d", fixed);
  endtask : bootCodes
  task automatic softStart();
    check("eaLow", eaLow, 1'h1);
    pins.ssAboveEaClamp <= 1'h1;
    pins.ssAtDischargeFloor <= 1'h0;
    tick(8);
    check("eaLow", eaLow, 1'h0);
    check("track", track, 1'h1);
    check("regulation_good_output", regulation_good_output, 1'h0);
    pins.ssAboveDelay <= 1'h1;
    tick(8);
    check("regulation_good_output", regulation_good_output, 1'h1);
    $display("soft start done");
  endtask : softStart
  // Late data setup on one command; refused addresses must leave state alone
  task automatic serialCmds();
    u_serial_voltage_code_host_model.park(1'h1, 1'h1);
    pins.powerReady <= 1'h1;
    tick(8);
    check("rxOn", rxOn, 1'h1);
    for (int i = 0; i < 8; i++) begin
      u_serial_voltage_code_host_model.lowExtra = (i == 2) ? 2 : 0;
      u_serial_voltage_code_host_model.send(adr[i], dat[i]);
      check("acks", u_serial_voltage_code_host_model.acks, {2{noAck[i]}});
      check("dac", dac, dacx[i]);
      check("psiN", psiN, psiBits[i]);
      if (i == 6) begin
        check("off", {eaLow, discharge, regulation_good_output}, 3'h7);
      end
    end
    check("charge", charge, 1'h1);
    $display("serial commands done");
  endtask : serialCmds
  task automatic powerOkDrop();
    pins.powerReady <= 1'h0;
    tick(8);
    check("rxOn", rxOn, 1'h0);
    check("dac", dac, 14'h1e3c);
    u_serial_voltage_code_host_model.send(8'hc4, 8'h10);
    check("acks", u_serial_voltage_code_host_model.acks, 2'h3);
    check("dac", dac, 14'h1e3c);
    $display("power ok drop done");
  endtask : powerOkDrop
  task automatic faults();
    pins.overCurrent <= 1'h1;
    tick(8);
    check("fault", {eaLow, regulation_good_output, discharge}, 3'h5);
    pins.overCurrent <= 1'h0;
    pins.ssAtDischargeFloor <= 1'h1;
    tick(8);
    check("charge", charge, 1'h1);
    for (int k = 0; k < 3; k++) begin
      {pins.overVoltage, pins.senseOpen, pins.chainOpen} <= 3'h4 >> k;
      tick(8);
      check("hard", {eaLow, regulation_good_output, discharge}, 3'h5);
      {pins.overVoltage, pins.senseOpen, pins.chainOpen} <= 3'h0;
      tick(8);
      check("held", discharge, 1'h1);
      pins.gateSupplyUv <= 1'h1;
      tick(8);
      check("uv", eaLow, 1'h1);
      pins.gateSupplyUv <= 1'h0;
      tick(8);
      check("charge", charge, 1'h1);
    end
    pins.ssBelowDisable <= 1'h1;
    tick(8);
    check("disabled", disabled, 1'h1);
    pins.ssBelowDisable <= 1'h0;
    $display("faults done");
  endtask : faults
  initial begin
    pins.ssAtDischargeFloor <= 1'h1;
    tick(6);
    rst <= 1'h0;
    tick(4);
    bootCodes(1'h1);
    bootCodes(1'h0);
    softStart();
    serialCmds();
    powerOkDrop();
    faults();
    wrapUp();
  end
endmodule : serial_vid_startup_control_tb

/* File: bench/serial_voltage_code_host_model.sv */
// Host side of the serial voltage-ID bus
`timescale 1ns/10ps
module serial_voltage_code_host_model (
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic busData,
  output logic vidClk,
  output logic hostData
);
  // *****
  // Bus cycles
  // *****
  logic [1:0] acks;
  // Delays each data change inside the low phase; bit time stays 800 ns, 2 at most
  int lowExtra = 0;
  initial begin
    vidClk = 1'h1;
    hostData = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic park(input logic c, input logic d);
    vidClk <= c;
    hostData <= d;
  endtask : park
  // Data moves only while clock is low, so no false start or stop
  task automatic bitOut(input logic b, output logic seen);
    vidClk <= 1'h0;
    tick(1 + lowExtra);
    hostData <= b;
    tick(3 - lowExtra);
    vidClk <= 1'h1;
    tick(2);
    seen = busData;
    tick(2);
  endtask : bitOut
  task automatic send(input logic [7:0] addr, input logic [7:0] data);
    logic s;
    hostData <= 1'h0;
    tick(4);
    for (int i = 7; i >= 0; i--) bitOut(addr[i], s);
    bitOut(1'h1, acks[1]);
    for (int i = 7; i >= 0; i--) bitOut(data[i], s);
    bitOut(1'h1, acks[0]);
    vidClk <= 1'h0;
    tick(2);
    hostData <= 1'h0;
    tick(2);
    vidClk <= 1'h1;
    tick(4);
    hostData <= 1'h1;
    tick(4);
  endtask : send
endmodule : serial_voltage_code_host_model

/* File: bench/serial_voltage_code_sva.sv */
// Concurrent checks on the start-up controller pins
`timescale 1ns/10ps
module serial_voltage_code_sva import serial_voltage_code_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic overCurrent,
  input wire logic overVoltage,
  input wire logic gateSupplyUv,
  input wire logic ssAboveEaClamp,
  input wire logic ssAboveDelay,
  input wire logic ssBelowDisable,
  // Watched outputs
  input wire logic serialVidDataOut,
  input wire logic serialVidDataOe,
  input wire logic errorAmpOutputHoldLow,
  input wire logic softstartDischarge,
  input wire logic regulationGoodOutput,
  input wire logic outputDisabled,
  input wire logic receiverEnabled,
  input wire dac_pair_t referenceDacLevel
);
  // *****
  // Properties
  // *****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  ack_low_a: assert property (serialVidDataOe |-> !serialVidDataOut)
    else $error("ack drives data high");
  ack_stands_a: assert property ($rose(serialVidDataOe) |=> serialVidDataOe[*6])
    else $error("ack too short");
  // Two sync stages plus the register put three samples between pin and power-good
  regulation_good_output_delay_a: assert property ($rose(regulationGoodOutput) |->
    $past(ssAboveDelay, 3))
    else $error("power good before delay");
  restart_fault_a: assert property ($rose(overCurrent) |-> ##[1:5]
    (errorAmpOutputHoldLow && softstartDischarge && !regulationGoodOutput))
    else $error("restart fault missed");
  hard_fault_a: assert property ($rose(overVoltage) |-> ##[1:5]
    (errorAmpOutputHoldLow && softstartDischarge && !regulationGoodOutput))
    else $error("hard fault missed");
  hard_hold_a: assert property ($fell(overVoltage) && !gateSupplyUv |->
    ##6 softstartDischarge)
    else $error("hard fault not held");
  dac_cmd_a: assert property ($changed(referenceDacLevel) && receiverEnabled
    && $past(receiverEnabled) |-> ##[1:8] serialVidDataOe)
    else $error("dac moved without command");
  idle_quiet_a: assert property ((!receiverEnabled)[*8] |-> !serialVidDataOe)
    else $error("ack while receiver off");
  ea_clamp_a: assert property ((!ssAboveEaClamp)[*4] |-> errorAmpOutputHoldLow)
    else $error("error amp released early");
  out_disable_a: assert property ($rose(ssBelowDisable) |-> ##[1:4] outputDisabled)
    else $error("disable not seen");
  cover property ($rose(regulationGoodOutput));
  cover property ($rose(serialVidDataOe));
  cover property ($fell(receiverEnabled));
endmodule : serial_voltage_code_sva
bind serial_vid_startup_control serial_voltage_code_sva u_serial_voltage_code_sva (.sys_clk, .rst, .overCurrent, .overVoltage,
  .gateSupplyUv, .ssAboveEaClamp, .ssAboveDelay, .ssBelowDisable, .serialVidDataOut,
  .serialVidDataOe, .errorAmpOutputHoldLow, .softstartDischarge, .regulationGoodOutput,
  .outputDisabled, .receiverEnabled, .referenceDacLevel);

/* File: logic/serial_vid_startup_control.sv */
// Start-up sequencing, fault latches and serial voltage-ID receiver
//
// What this block does
// - On enable rise without fault, latch two-pin boot code, start soft start, set DACs.
// - Boot code clock,data: 00=1.1V, 01=1.0V, 10=0.9V, 11=0.8V.
// - Fixed mode code clock,data: 00=1.4V, 01=1.2V, 10=1.0V, 11=0.8V, both DACs.
// - Hold error amp low until node reaches 1.4V, then track node minus offset.
// - Power-good may rise only once node passes the delay comparator threshold.
// - Power-ok enables the receiver outside fixed mode; afterwards only commands change DAC targets.
// - Gate-supply undervoltage, over-current or enable low set restartable latch at once.
// - Restartable latch forces error amp low, power-good low, discharges node.
// - Discharge comparator trip with cause gone clears latch and restarts soft start.
// - Over-voltage, open sense, open chain latch until gate supply cycles; same effects.
// - Off codes discharge node and hold error amp low, power-good unchanged.
// - A non-off code after an off code restarts soft start at new voltage.
// - Node held below 0.6V externally means output disabled.
// - Serial clock pin is input only; never driven, never stretched.
// - Receiver idles until data falls while clock is high.
// - Acknowledge only one of three addresses; otherwise no ack, ignore transaction.
// - Acknowledge by driving data pin low through the acknowledge bit.
// - Data bit 7 high releases power-save output; low drives it low.
// - Bits 6..0: 0 is 1.55V, 12.5mV steps down, floor 0.5V below off codes.
// - Acknowledge data; non-off byte updates addressed DAC targets immediately.
// - Address 110xx100 output 1, 110xx010 output 2, 110xx110 both; x ignored.
// - Power-ok tied to gate rail at enable selects the fixed code table.
// - Keep boot code; power-ok drop with enable high returns DACs to it.
`timescale 1ns/10ps
`include "serial_voltage_code_params.svh"

module serial_vid_startup_control import serial_voltage_code_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control pins
  input wire logic enableIn,
  input wire logic hostPowerReadyInput,
  input wire logic powerReadyAtGateRail,
  // Fault detectors
  input wire logic gateSupplyUv,
  input wire logic overCurrent,
  input wire logic overVoltage,
  input wire logic remoteSenseLinesOpen,
  input wire logic phaseChainOpen,
  // Soft-start node comparators
  input wire logic ssAboveEaClamp,
  input wire logic ssAboveDelay,
  input wire logic ssAtDischargeFloor,
  input wire logic ssBelowDisable,
  // Serial voltage-ID pins
  input wire logic serialVidClock,
  input wire logic serialVidDataIn,
  output logic serialVidDataOut,
  output logic serialVidDataOe,
  // Analog control outputs
  output logic errorAmpOutputHoldLow,
  output logic trackSoftstart,
  output logic softstartCharge,
  output logic softstartDischarge,
  output logic regulationGoodOutput,
  output logic outputDisabled,
  output logic powerSaveIndicator_n,
  output dac_pair_t referenceDacLevel,
  // Status
  output logic fixedVoltageMode,
  output logic receiverEnabled
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  pin_in_t pinsRaw;
  pin_in_t pinsMeta_reg;
  pin_in_t pins;
  logic enablePrev_reg;
  logic powerPrev_reg;
  logic clockPrev_reg;
  logic dataPrev_reg;

  assign pinsRaw = '{enable: enableIn, powerReady: hostPowerReadyInput,
                     powerReadyAtRail: powerReadyAtGateRail, gateSupplyUv: gateSupplyUv,
                     overCurrent: overCurrent, overVoltage: overVoltage,
                     senseOpen: remoteSenseLinesOpen, chainOpen: phaseChainOpen,
                     ssAboveEaClamp: ssAboveEaClamp, ssAboveDelay: ssAboveDelay,
                     ssAtDischargeFloor: ssAtDischargeFloor, ssBelowDisable: ssBelowDisable,
                     vidClock: serialVidClock, vidData: serialVidDataIn};

  always_ff @(posedge sys_clk) begin
    pinsMeta_reg <= pinsRaw;
    pins <= pinsMeta_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      enablePrev_reg <= 1'b0;
      powerPrev_reg <= 1'b0;
      clockPrev_reg <= 1'b1;
      dataPrev_reg <= 1'b1;
    end else begin
      enablePrev_reg <= pins.enable;
      powerPrev_reg <= pins.powerReady;
      clockPrev_reg <= pins.vidClock;
      dataPrev_reg <= pins.vidData;
    end
  end

  logic enableRise;
  logic powerFall;
  logic clockRise;
  logic clockFall;
  logic startCond;
  logic stopCond;

  assign enableRise = pins.enable & ~enablePrev_reg;
  assign powerFall = ~pins.powerReady & powerPrev_reg;
  assign clockRise = pins.vidClock & ~clockPrev_reg;
  assign clockFall = ~pins.vidClock & clockPrev_reg;
  assign startCond = pins.vidClock & clockPrev_reg & dataPrev_reg & ~pins.vidData;
  assign stopCond = pins.vidClock & clockPrev_reg & ~dataPrev_reg & pins.vidData;

  // ****************************************
  // Fault latches
  // ****************************************
  logic restartFault_reg;
  hard_fault_t hardFault_reg;
  logic restartCause;
  logic restartFaultNow;
  logic anyFault;

  assign restartCause = pins.gateSupplyUv | pins.overCurrent | ~pins.enable;
  assign restartFaultNow = restartFault_reg | restartCause;
  assign anyFault = restartFaultNow | (|hardFault_reg);

  // Set wins over the floor-reached clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      restartFault_reg <= 1'b0;
    end else if (restartCause) begin
      restartFault_reg <= 1'b1;
    end else if (restartFault_reg && pins.ssAtDischargeFloor) begin
      restartFault_reg <= 1'b0;
    end
  end

  // Only a gate supply collapse clears these, which is what power cycling looks like
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hardFault_reg <= '0;
    end else begin
      hardFault_reg.overVoltage <= pins.overVoltage |
                                   (hardFault_reg.overVoltage & ~pins.gateSupplyUv);
      hardFault_reg.senseOpen <= pins.senseOpen |
                                 (hardFault_reg.senseOpen & ~pins.gateSupplyUv);
      hardFault_reg.chainOpen <= pins.chainOpen |
                                 (hardFault_reg.chainOpen & ~pins.gateSupplyUv);
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  rx_state_t rxState_reg;
  logic [7:0] shift_reg;
  logic [2:0] bitCount_reg;
  logic [1:0] targetSel_reg;
  logic fixedMode_reg;
  logic rxEnable;
  logic [7:0] byteNext;
  logic addrMatch;
  logic cmdStrobe;
  logic offCode;
  logic nonOffCmd;
  logic offCmd;

  assign rxEnable = pins.powerReady & pins.enable & ~fixedMode_reg;
  assign byteNext = {shift_reg[6:0], pins.vidData};
  assign addrMatch = (byteNext[7:5] == `ADDR_PREFIX) && (byteNext[0] == `ADDR_WRITE) &&
                     (byteNext[2:1] != `SEL_NONE);
  assign cmdStrobe = (rxState_reg == RX_DATA) && clockRise && (bitCount_reg == `BIT_LAST);
  assign offCode = byteNext[6:0] >= `CODE_OFF_MIN;
  assign nonOffCmd = cmdStrobe & ~offCode;
  assign offCmd = cmdStrobe & offCode;

  always_ff @(posedge sys_clk) begin
    if (rst || !rxEnable) begin
      rxState_reg <= RX_IDLE;
      bitCount_reg <= `BIT_FIRST;
      serialVidDataOe <= 1'b0;
    end else if (startCond) begin
      rxState_reg <= RX_ADDR;
      bitCount_reg <= `BIT_FIRST;
      serialVidDataOe <= 1'b0;
    end else if (stopCond) begin
      rxState_reg <= RX_IDLE;
      serialVidDataOe <= 1'b0;
    end else begin
      case (rxState_reg)
        RX_ADDR, RX_DATA: begin
          if (clockRise) begin
            bitCount_reg <= bitCount_reg + 3'h1;
            if (bitCount_reg == `BIT_LAST) begin
              if (rxState_reg == RX_DATA) begin
                rxState_reg <= RX_DATA_ACK;
              end else if (addrMatch) begin
                rxState_reg <= RX_ADDR_ACK;
              end else begin
                rxState_reg <= RX_IGNORE;
              end
            end
          end
        end
        RX_ADDR_ACK, RX_DATA_ACK: begin
          // Drive low from the fall after bit 8 to the fall after the ack clock
          if (clockFall) begin
            serialVidDataOe <= ~serialVidDataOe;
            if (serialVidDataOe) begin
              bitCount_reg <= `BIT_FIRST;
              rxState_reg <= (rxState_reg == RX_ADDR_ACK) ? RX_DATA : RX_IDLE;
            end
          end
        end
        RX_IDLE, RX_IGNORE: begin
          serialVidDataOe <= 1'b0;
        end
        default: begin
          rxState_reg <= RX_IDLE;
          serialVidDataOe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (clockRise) begin
      shift_reg <= byteNext;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      targetSel_reg <= `SEL_NONE;
    end else if ((rxState_reg == RX_ADDR) && clockRise && (bitCount_reg == `BIT_LAST)) begin
      targetSel_reg <= byteNext[2:1];
    end
  end

  // ****************************************
  // Voltage targets
  // ****************************************
  logic [1:0] bootCode_reg;
  logic [6:0] cmdLevel;

  function automatic logic [6:0] pairLevel(input logic fixedMode, input logic [1:0] code);
    logic [6:0] level;
    level = `CODE_0V80;
    case (code)
      `PAIR_00: level = fixedMode ? `CODE_1V40 : `CODE_1V10;
      `PAIR_01: level = fixedMode ? `CODE_1V20 : `CODE_1V00;
      `PAIR_10: level = fixedMode ? `CODE_1V00 : `CODE_0V90;
      default: level = `CODE_0V80;
    endcase
    return level;
  endfunction : pairLevel

  // Codes from the floor up to the off codes all give the floor voltage
  assign cmdLevel = (byteNext[6:0] > `CODE_FLOOR) ? `CODE_FLOOR : byteNext[6:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bootCode_reg <= `PAIR_00;
      fixedMode_reg <= 1'b0;
    end else if (enableRise && !restartCause && !(|hardFault_reg)) begin
      bootCode_reg <= {pins.vidClock, pins.vidData};
      fixedMode_reg <= pins.powerReadyAtRail;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      referenceDacLevel <= '{level1: `DAC_RESET_CODE, level2: `DAC_RESET_CODE};
    end else if (enableRise && !restartCause && !(|hardFault_reg)) begin
      referenceDacLevel.level1 <= pairLevel(pins.powerReadyAtRail,
                                            {pins.vidClock, pins.vidData});
      referenceDacLevel.level2 <= pairLevel(pins.powerReadyAtRail,
                                            {pins.vidClock, pins.vidData});
    end else if (powerFall && pins.enable && !fixedMode_reg) begin
      referenceDacLevel.level1 <= pairLevel(1'b0, bootCode_reg);
      referenceDacLevel.level2 <= pairLevel(1'b0, bootCode_reg);
    end else if (nonOffCmd) begin
      if (targetSel_reg[1]) begin
        referenceDacLevel.level1 <= cmdLevel;
      end
      if (targetSel_reg[0]) begin
        referenceDacLevel.level2 <= cmdLevel;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      powerSaveIndicator_n <= `PSI_RESET;
    end else if (cmdStrobe) begin
      powerSaveIndicator_n <= byteNext[7];
    end
  end

  // ****************************************
  // Power sequence
  // ****************************************
  pwr_state_t pwrState_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwrState_reg <= PWR_FAULT;
    end else if (anyFault) begin
      pwrState_reg <= PWR_FAULT;
    end else begin
      case (pwrState_reg)
        PWR_FAULT: pwrState_reg <= PWR_SOFTSTART;
        PWR_SOFTSTART, PWR_RUN: begin
          if (offCmd) begin
            pwrState_reg <= PWR_VIDOFF;
          end else if (pwrState_reg == PWR_SOFTSTART && pins.ssAboveDelay) begin
            pwrState_reg <= PWR_RUN;
          end else if (pins.ssBelowDisable) begin
            pwrState_reg <= PWR_SOFTSTART;
          end
        end
        PWR_VIDOFF: begin
          if (nonOffCmd) begin
            pwrState_reg <= PWR_SOFTSTART;
          end
        end
        default: pwrState_reg <= PWR_FAULT;
      endcase
    end
  end

  // Power-good is held, not cleared, through an off code
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regulationGoodOutput <= 1'b0;
    end else if (anyFault || pins.ssBelowDisable) begin
      regulationGoodOutput <= 1'b0;
    end else if (pwrState_reg == PWR_SOFTSTART && pins.ssAboveDelay) begin
      regulationGoodOutput <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign softstartDischarge = anyFault || pwrState_reg == PWR_FAULT ||
                              pwrState_reg == PWR_VIDOFF;
  assign softstartCharge = ~softstartDischarge;
  assign errorAmpOutputHoldLow = softstartDischarge | ~pins.ssAboveEaClamp |
                                 pins.ssBelowDisable;
  assign trackSoftstart = (pwrState_reg == PWR_SOFTSTART) & ~errorAmpOutputHoldLow;
  assign outputDisabled = pins.ssBelowDisable;
  assign serialVidDataOut = `ACK_LEVEL;
  assign fixedVoltageMode = fixedMode_reg;
  assign receiverEnabled = rxEnable;
  // The clock pin has no output path at all, so it can never be stretched

endmodule : serial_vid_startup_control

/* File: logic/serial_voltage_code_params.svh */
// Constants for the serial voltage-ID start-up controller
`ifndef SERIAL_VOLTAGE_CODE_PARAMS_SVH
`define SERIAL_VOLTAGE_CODE_PARAMS_SVH
// Voltage codes, 12.5 mV per step down from 1.5500 V
`define CODE_1V40 7'h0c
`define CODE_1V20 7'h1c
`define CODE_1V10 7'h24
`define CODE_1V00 7'h2c
`define CODE_0V90 7'h34
`define CODE_0V80 7'h3c
`define CODE_FLOOR 7'h54
`define CODE_OFF_MIN 7'h7c
`define DAC_RESET_CODE 7'h7c
// Two-pin code values, clock pin level then data pin level
`define PAIR_00 2'h0
`define PAIR_01 2'h1
`define PAIR_10 2'h2
// Address byte fields, write bit included; bit counts, ack and power-save levels
`define ADDR_PREFIX 3'h6
`define ADDR_WRITE 1'h0
`define SEL_NONE 2'h0
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define ACK_LEVEL 1'h0
`define PSI_RESET 1'h1
`endif

/* File: logic/serial_voltage_code_pkg.sv */
// Types shared by the serial voltage-ID start-up controller
package serial_voltage_code_pkg;
  typedef enum logic [1:0] {PWR_FAULT, PWR_SOFTSTART, PWR_RUN, PWR_VIDOFF} pwr_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_ADDR, RX_ADDR_ACK, RX_DATA, RX_DATA_ACK, RX_IGNORE}
    rx_state_t;
  typedef struct packed {
    logic enable;
    logic powerReady;
    logic powerReadyAtRail;
    logic gateSupplyUv;
    logic overCurrent;
    logic overVoltage;
    logic senseOpen;
    logic chainOpen;
    logic ssAboveEaClamp;
    logic ssAboveDelay;
    logic ssAtDischargeFloor;
    logic ssBelowDisable;
    logic vidClock;
    logic vidData;
  } pin_in_t;
  typedef struct packed {
    logic overVoltage;
    logic senseOpen;
    logic chainOpen;
  } hard_fault_t;
  typedef struct packed {
    logic [6:0] level1;
    logic [6:0] level2;
  } dac_pair_t;
endpackage : serial_voltage_code_pkg
